// ---- spe_annun.sv ----
// Purpose: Per-state acknowledge and silence tracking
// Assumes: Rise is a one-cycle pulse on a new or re-reported event
// Notes:   A new event wins over an acknowledge in the same cycle
`timescale 1ns/100ps
module spe_annun (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // State and operator
  input  wire logic active,
  input  wire logic rise,
  input  wire logic ack,
  input  wire logic silence,
  // Status
  output logic      flashing,
  output logic      silenced
);
  logic flashReg;
  logic flashNext;
  logic silReg;
  logic silNext;

  always_comb
  begin
    flashNext = rise | (flashReg & active & !ack);
    silNext   = !rise & active & (silReg | silence);
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      flashReg <= 1'b0;
      silReg   <= 1'b0;
    end
    else
    begin
      flashReg <= flashNext;
      silReg   <= silNext;
    end
  end

  assign flashing = flashReg;
  assign silenced = silReg;
endmodule

// ---- spe_cd_if.sv ----
// Purpose: Countdown control group between the state controller and the timer
// Assumes: Single sys_clk domain
// Notes:   Tick is a one-cycle pulse per second
`timescale 1ns/100ps
interface spe_cd_if;
  logic            load;
  spe_pkg::spe_sec_t loadVal;
  logic            run;
  logic            tick;
  spe_pkg::spe_sec_t count;
  logic            zero;

  modport ctl (output load, output loadVal, output run, output tick,
               input count, input zero);
  modport cnt (input load, input loadVal, input run, input tick,
               output count, output zero);
endinterface

// ---- spe_countdown.sv ----
// Purpose: Seconds countdown for pre-discharge
// Assumes: Load has priority over counting
// Notes:   Halts at zero; run low freezes the count during abort
`timescale 1ns/100ps
module spe_countdown (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Control group
  spe_cd_if.cnt    cd
);
  spe_pkg::spe_sec_t countReg;
  spe_pkg::spe_sec_t countNext;

  always_comb
  begin
    countNext = countReg;
    if (cd.load)
    begin
      countNext = cd.loadVal;
    end
    else if (cd.run && cd.tick && (countReg != '0))
    begin
      countNext = countReg - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      countReg <= '0;
    end
    else
    begin
      countReg <= countNext;
    end
  end

  assign cd.count = countReg;
  assign cd.zero  = (countReg == '0);
endmodule

// ---- spe_event_states.sv ----
// Purpose: Event-state controller of a suppression control panel
// Assumes: All inputs synchronous to sys_clk; buttons are one-cycle pulses
// Notes:   Flash and warble rates come from one divider; long counts in seconds
`timescale 1ns/100ps
module spe_event_states #(
  parameter int HALF_CYC_P = spe_pkg::HALF_CYC,
  parameter int VERIFY_S   = spe_pkg::VERIFY_S_DEF
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  // Event reports
  input  wire logic                  sumAlarmIn,
  input  wire logic                  verifyAboveIn,
  input  wire logic                  troubleIn,
  input  wire logic                  loopOpenFlt,
  input  wire logic                  loopShortFlt,
  input  wire logic                  sensorDriftFault,
  input  wire logic                  supervisoryIn,
  input  wire logic                  zoneDisableIn,
  input  wire logic                  detectPreDisIn,
  input  wire logic                  manualPreDisIn,
  input  wire logic                  manualReleaseIn,
  input  wire logic                  abortIn,
  // Operator buttons
  input  wire logic                  ackBtn,
  input  wire logic                  silenceBtn,
  input  wire logic                  panelResetBtn,
  input  wire logic                  anyBtn,
  // Configuration
  input  wire logic                  sumAsAlarmCfg,
  input  wire logic                  verifyEnCfg,
  input  wire logic                  supvLatchCfg,
  input  wire logic                  autoCdSelCfg,
  input  wire logic                  manualCdSelCfg,
  input  wire logic                  abortRestartCfg,
  input  wire spe_pkg::spe_sec_t     autoDelayCfg,
  input  wire spe_pkg::spe_sec_t     manualDelayCfg,
  input  wire logic [5:0]            silenceableCfg,
  // Indicators
  output logic [5:0]                 stateLed,
  output logic                       supervisoryIndicator,
  output logic                       sounderOn,
  // Zone and relay outputs
  output logic [5:0]                 zoneOut,
  output logic                       verifyZoneOut,
  output logic                       globalNondisableableZone,
  output logic                       troubleRelayConnector,
  output logic                       invalidAbortTrouble,
  output spe_pkg::spe_sec_t          countdownSec,
  // Event log and display
  output logic                       eventStb,
  output logic [2:0]                 eventCode,
  output logic                       eventView
);
  spe_cd_if cd ();

  // Divider: half-second flash phase, one-second warble phase
  logic [31:0] halfCntReg, halfCntNext;
  logic        flashReg, flashNext, warbleReg, warbleNext;
  logic        halfTick, secTick;

  assign halfTick = (halfCntReg == 32'(HALF_CYC_P - 1));
  assign secTick  = halfTick & flashReg;

  always_comb
  begin
    halfCntNext = halfTick ? '0 : halfCntReg + 32'h0000_0001;
    flashNext   = flashReg ^ halfTick;
    warbleNext  = warbleReg ^ secTick;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      halfCntReg <= '0;
      flashReg   <= 1'b0;
      warbleReg  <= 1'b0;
    end
    else
    begin
      halfCntReg <= halfCntNext;
      flashReg   <= flashNext;
      warbleReg  <= warbleNext;
    end
  end

  // Latched events and verification
  logic             sumReg, sumNext, trbReg, trbNext, supvReg, supvNext;
  logic             verAlmReg, verAlmNext;
  spe_pkg::spe_ver_e verReg, verNext;
  logic [7:0]       verSecReg, verSecNext;
  logic             alarmPresent, abortValid, invAbort;

  assign alarmPresent = (sumReg & sumAsAlarmCfg) | verAlmReg;
  assign abortValid   = abortIn & alarmPresent;
  assign invAbort     = abortIn & !alarmPresent;

  always_comb
  begin
    // Set wins over reset so a standing condition stays reported
    sumNext  = sumAlarmIn | (sumReg & !panelResetBtn);
    trbNext  = loopOpenFlt | loopShortFlt | sensorDriftFault
             | (trbReg & !panelResetBtn);
    supvNext = (supervisoryIn & supvLatchCfg) | (supvReg & !panelResetBtn);
    verNext    = verReg;
    verSecNext = verSecReg;
    verAlmNext = (verAlmReg & !panelResetBtn) | (verifyAboveIn & !verifyEnCfg);
    unique case (verReg)
      spe_pkg::VER_IDLE:
      begin
        if (verifyAboveIn && verifyEnCfg && !verAlmReg)
        begin
          verNext    = spe_pkg::VER_RUN;
          verSecNext = '0;
        end
      end
      spe_pkg::VER_RUN:
      begin
        if (!verifyAboveIn)
        begin
          verNext = spe_pkg::VER_IDLE;
        end
        else if (secTick && (verSecReg == 8'(VERIFY_S - 1)))
        begin
          verNext    = spe_pkg::VER_IDLE;
          verAlmNext = 1'b1;
        end
        else if (secTick)
        begin
          verSecNext = verSecReg + 8'h01;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sumReg    <= 1'b0;
      trbReg    <= 1'b0;
      supvReg   <= 1'b0;
      verAlmReg <= 1'b0;
      verReg    <= spe_pkg::VER_IDLE;
      verSecReg <= '0;
    end
    else
    begin
      sumReg    <= sumNext;
      trbReg    <= trbNext;
      supvReg   <= supvNext;
      verAlmReg <= verAlmNext;
      verReg    <= verNext;
      verSecReg <= verSecNext;
    end
  end

  // Pre-discharge, abort and release sequencing
  spe_pkg::spe_pd_e pdReg, pdNext;
  logic             manPrevReg, manRise;

  assign manRise = manualPreDisIn & !manPrevReg & manualCdSelCfg;
  assign cd.tick = secTick;
  assign cd.run  = (pdReg == spe_pkg::PD_COUNT);

  always_comb
  begin
    pdNext     = pdReg;
    cd.load    = 1'b0;
    cd.loadVal = autoDelayCfg;
    unique case (pdReg)
      spe_pkg::PD_IDLE:
      begin
        if (manualReleaseIn)
          pdNext = spe_pkg::PD_RELEASE;
        else if (manualPreDisIn && manualCdSelCfg)
        begin
          pdNext     = spe_pkg::PD_COUNT;
          cd.load    = 1'b1;
          cd.loadVal = manualDelayCfg;
        end
        else if (detectPreDisIn && autoCdSelCfg)
        begin
          pdNext  = spe_pkg::PD_COUNT;
          cd.load = 1'b1;
        end
      end
      spe_pkg::PD_COUNT, spe_pkg::PD_ABORT:
      begin
        if (manualReleaseIn)
          pdNext = spe_pkg::PD_RELEASE;
        else if (manRise)
        begin
          pdNext     = spe_pkg::PD_COUNT;
          cd.load    = 1'b1;
          cd.loadVal = manualDelayCfg;
        end
        else if (abortValid)
          pdNext = spe_pkg::PD_ABORT;
        else if (cd.zero)
          pdNext = spe_pkg::PD_RELEASE;
        else if (pdReg == spe_pkg::PD_ABORT)
        begin
          pdNext  = spe_pkg::PD_COUNT;
          cd.load = abortRestartCfg;
        end
      end
      spe_pkg::PD_RELEASE:
      begin
        pdNext = spe_pkg::PD_RELEASE;
      end
    endcase
    if (panelResetBtn)
      pdNext = spe_pkg::PD_IDLE;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pdReg      <= spe_pkg::PD_IDLE;
      manPrevReg <= 1'b0;
    end
    else
    begin
      pdReg      <= pdNext;
      manPrevReg <= manualPreDisIn;
    end
  end

  spe_countdown u_cd (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .cd      (cd.cnt)
  );

  // Indicator states and per-state acknowledge tracking
  logic [5:0] act, actPrevReg, annRise, flashing, silenced;
  logic       ackAny;

  always_comb
  begin
    act                   = '0;
    act[spe_pkg::IX_REL]  = (pdReg == spe_pkg::PD_RELEASE);
    act[spe_pkg::IX_PRED] = (pdReg != spe_pkg::PD_IDLE);
    act[spe_pkg::IX_ABORT] = abortValid;
    act[spe_pkg::IX_ALM]  = alarmPresent;
    act[spe_pkg::IX_SUPV] = supervisoryIn | supvReg | zoneDisableIn
                          | (sumReg & !sumAsAlarmCfg);
    act[spe_pkg::IX_TRB]  = troubleIn | trbReg | invAbort | zoneDisableIn;
  end

  assign ackAny  = ackBtn | silenceBtn;
  assign annRise = act & (~actPrevReg | {6{panelResetBtn}});

  for (genvar g = 0; g < spe_pkg::NST; g++)
  begin : g_ann
    spe_annun u_ann (
      .sys_clk  (sys_clk),
      .rst_b    (rst_b),
      .active   (act[g]),
      .rise     (annRise[g]),
      .ack      (ackAny),
      .silence  (silenceBtn),
      .flashing (flashing[g]),
      .silenced (silenced[g])
    );
  end

  // Event log queue and display view
  logic [7:0]        evAct, evPrevReg, evRise, pendReg, pendNext, grant;
  logic              stbNext, viewReg, viewNext;
  logic [2:0]        codeNext;
  logic [6:0]        dispSecReg, dispSecNext;

  always_comb
  begin
    // Abort input is logged even when invalid, so its invalid entry comes first
    evAct = {act[spe_pkg::IX_REL], abortIn, act[spe_pkg::IX_PRED],
             act[spe_pkg::IX_SUPV], act[spe_pkg::IX_TRB], (verReg == spe_pkg::VER_RUN),
             alarmPresent, invAbort};
    evRise   = evAct & (~evPrevReg | {8{panelResetBtn}});
    grant    = '0;
    codeNext = '0;
    // Lowest code first so an invalid abort precedes its abort
    for (int k = spe_pkg::NEV - 1; k >= 0; k--)
    begin
      if (pendReg[k])
      begin
        grant    = 8'h01 << k;
        codeNext = 3'(k);
      end
    end
    pendNext    = (pendReg & ~grant) | evRise;
    stbNext     = |pendReg;
    viewNext    = viewReg;
    dispSecNext = dispSecReg;
    if (|evRise)
    begin
      viewNext    = 1'b1;
      dispSecNext = '0;
    end
    else if (anyBtn || ackBtn || silenceBtn || panelResetBtn)
      dispSecNext = '0;
    else if (viewReg && secTick && (dispSecReg == 7'(spe_pkg::DISP_TIMEOUT_S - 1)))
      viewNext = 1'b0;
    else if (viewReg && secTick)
      dispSecNext = dispSecReg + 7'h01;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      evPrevReg  <= '0;
      actPrevReg <= '0;
      pendReg    <= '0;
      eventStb   <= 1'b0;
      eventCode  <= '0;
      viewReg    <= 1'b0;
      dispSecReg <= '0;
    end
    else
    begin
      evPrevReg  <= evAct;
      actPrevReg <= act;
      pendReg    <= pendNext;
      eventStb   <= stbNext;
      eventCode  <= codeNext;
      viewReg    <= viewNext;
      dispSecReg <= dispSecNext;
    end
  end

  assign eventView = viewReg;

  // Output drive
  logic [5:0] ledNext, zoneNext;
  logic       sndNext;

  always_comb
  begin
    ledNext  = '0;
    zoneNext = '0;
    sndNext  = 1'b0;
    for (int i = 0; i < spe_pkg::NST; i++)
    begin
      ledNext[i]  = act[i] & (!flashing[i] | flashReg);
      zoneNext[i] = act[i] & !(silenced[i] & silenceableCfg[i]);
    end
    // Most urgent unacknowledged state owns the sounder
    for (int i = spe_pkg::NST - 1; i >= 0; i--)
    begin
      // Flash bit drains one cycle after a restore; an idle state must stay quiet
      if (flashing[i] && act[i])
      begin
        if (i == spe_pkg::IX_TRB)
          sndNext = 1'b1;
        else if (i == spe_pkg::IX_SUPV)
          sndNext = warbleReg;
        else if (i == spe_pkg::IX_ABORT)
          sndNext = flashReg ^ warbleReg;
        else
          sndNext = flashReg;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stateLed                 <= '0;
      supervisoryIndicator     <= 1'b0;
      sounderOn                <= 1'b0;
      zoneOut                  <= '0;
      verifyZoneOut            <= 1'b0;
      globalNondisableableZone <= 1'b0;
      troubleRelayConnector    <= spe_pkg::RELAY_RST;
      invalidAbortTrouble      <= 1'b0;
      countdownSec             <= '0;
    end
    else
    begin
      stateLed                 <= ledNext;
      supervisoryIndicator     <= ledNext[spe_pkg::IX_SUPV];
      sounderOn                <= sndNext;
      zoneOut                  <= zoneNext;
      verifyZoneOut            <= (verReg == spe_pkg::VER_RUN);
      globalNondisableableZone <= sumReg;
      troubleRelayConnector    <= !act[spe_pkg::IX_TRB];
      invalidAbortTrouble      <= invAbort;
      countdownSec             <= cd.count;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  AST_GLOBAL_ZONE: assert property (sumAlarmIn |-> ##2 globalNondisableableZone)
    else $error("global zone not driven by summing alarm");
  AST_SUM_LATCH: assert property (sumReg && !panelResetBtn |=> sumReg)
    else $error("summing alarm dropped without reset");
  AST_RELAY: assert property (troubleIn |=> !troubleRelayConnector)
    else $error("trouble relay still energized");
  AST_QUIET: assert property (act == '0 |=> !sounderOn && stateLed == '0)
    else $error("indicator or sounder on with no state");
  AST_REL_ZERO: assert property (pdReg == spe_pkg::PD_COUNT && !cd.zero && !manualReleaseIn
                                 |=> pdReg != spe_pkg::PD_RELEASE)
    else $error("release before countdown end");
  AST_REL_LATCH: assert property (pdReg == spe_pkg::PD_RELEASE && !panelResetBtn
                                  |=> pdReg == spe_pkg::PD_RELEASE)
    else $error("release dropped without reset");
  AST_OVERRIDE: assert property (pdReg == spe_pkg::PD_ABORT && manualReleaseIn
                                 && !panelResetBtn |=> pdReg == spe_pkg::PD_RELEASE)
    else $error("manual release did not override abort");
  AST_INV_ABORT: assert property (abortIn && !alarmPresent |=> invalidAbortTrouble
                                  && pdReg != spe_pkg::PD_ABORT)
    else $error("invalid abort not flagged");
  AST_OUT_HOLD: assert property (act[spe_pkg::IX_ALM] && !silenceableCfg[spe_pkg::IX_ALM]
                                 && $stable(silenceableCfg)
                                 |=> zoneOut[spe_pkg::IX_ALM])
    else $error("non-silenceable alarm output dropped");

  COV_RELEASE: cover property (pdReg == spe_pkg::PD_COUNT ##1 pdReg == spe_pkg::PD_RELEASE);
  COV_ABORT_RESUME: cover property (pdReg == spe_pkg::PD_ABORT ##1 pdReg == spe_pkg::PD_COUNT);
  COV_VERIFY_ALARM: cover property (verReg == spe_pkg::VER_RUN ##1 verAlmReg);
  COV_TIMEOUT: cover property (viewReg ##1 !viewReg);
endmodule

// ---- spe_event_states_bench.sv ----
// Purpose: Self-checking bench for the panel event-state block
// Assumes: Flash half period 4 cycles, so one second is 8 cycles
// Notes:   Event bits 0..11 follow the design's event input order
`timescale 1ns/100ps
module spe_event_states_bench;
  logic              sys_clk = 1'b0;
  logic              rst_b = 1'b0;
  logic [11:0]       ev = 12'h000;
  logic [3:0]        btn = 4'h0;
  logic [11:0]       evD;
  logic [3:0]        btnD;
  logic              sumAsAlarmCfg = 1'b1, verifyEnCfg = 1'b0, supvLatchCfg = 1'b0;
  logic              autoCdSelCfg = 1'b1, manualCdSelCfg = 1'b1, abortRestartCfg = 1'b0;
  spe_pkg::spe_sec_t autoDelayCfg = 8'h03, manualDelayCfg = 8'h01;
  logic [5:0]        silenceableCfg = 6'h3f, led, zone;
  logic              supI, snd, verZ, gz, relay, invA, stb, view;
  logic [2:0]        code;
  spe_pkg::spe_sec_t cdSec;
  logic [2:0]        evq[$];
  int                errors = 0, n_tests = 0, on, sn;

  spe_field_devices spe_field_devices_i (.sys_clk, .evReq(ev), .btnReq(btn),
    .evOut(evD), .btnOut(btnD));

  spe_event_states #(.HALF_CYC_P(4), .VERIFY_S(3)) spe_event_states_i (
    .sys_clk, .rst_b, .sumAlarmIn(evD[0]), .verifyAboveIn(evD[1]), .troubleIn(evD[2]),
    .loopOpenFlt(evD[3]), .loopShortFlt(evD[4]), .sensorDriftFault(evD[5]),
    .supervisoryIn(evD[6]), .zoneDisableIn(evD[7]), .detectPreDisIn(evD[8]),
    .manualPreDisIn(evD[9]), .manualReleaseIn(evD[10]), .abortIn(evD[11]),
    .ackBtn(btnD[0]), .silenceBtn(btnD[1]), .panelResetBtn(btnD[2]), .anyBtn(btnD[3]),
    .sumAsAlarmCfg, .verifyEnCfg, .supvLatchCfg, .autoCdSelCfg, .manualCdSelCfg,
    .abortRestartCfg, .autoDelayCfg, .manualDelayCfg, .silenceableCfg,
    .stateLed(led), .supervisoryIndicator(supI), .sounderOn(snd), .zoneOut(zone),
    .verifyZoneOut(verZ), .globalNondisableableZone(gz), .troubleRelayConnector(relay),
    .invalidAbortTrouble(invA), .countdownSec(cdSec), .eventStb(stb),
    .eventCode(code), .eventView(view));

  initial
    forever #12.5 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
    if (stb === 1'b1)
      evq.push_back(code);

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  task automatic press(input int b);
    btn[b] = 1'b1;
    cyc(1);
    btn[b] = 1'b0;
    cyc(3);
  endtask

  // Counts lamp and sounder on-cycles over two seconds
  task automatic watch(input int b);
    on = 0;
    sn = 0;
    repeat (16)
    begin
      cyc(1);
      on += (led[b] === 1'b1);
      sn += (snd === 1'b1);
    end
  endtask

  task automatic clr;
    ev = 12'h000;
    press(2);
    cyc(4);
    evq.delete();
  endtask

  task automatic t_trouble;
    ev[2] = 1'b1;
    cyc(4);
    chk("relayTrb", relay, 0);
    watch(5);
    chk("trbFlash", on > 0 && on < 16 && sn == 16, 1);
    press(0);
    watch(5);
    chk("trbAck", on == 16 && sn == 0, 1);
    ev[2] = 1'b0;
    cyc(4);
    chk("trbGone", {relay, led[5], evq[0]}, 5'h13);
    for (int i = 3; i <= 5; i++)
    begin
      ev[i] = 1'b1;
      cyc(3);
      ev[i] = 1'b0;
      cyc(4);
      chk("latchTrb", relay, 0);
      clr();
      chk("latchClr", relay, 1);
    end
  endtask

  task automatic t_alarm;
    silenceableCfg = 6'h37;
    ev[2:0] = 3'b101;
    cyc(4);
    chk("globalZone", gz, 1);
    watch(3);
    chk("almPulse", on > 0 && on < 16 && sn > 0 && sn < 16, 1);
    ev[0] = 1'b0;
    press(1);
    watch(3);
    chk("almSil", on == 16 && sn == 0 && gz, 1);
    chk("zoneSil", zone[5:3], 3'b001);
    clr();
    chk("almClr", {gz, led[3]}, 0);
    silenceableCfg = 6'h3f;
  endtask

  task automatic t_inv_abort;
    ev[11] = 1'b1;
    cyc(6);
    chk("invAbort", invA, 1);
    chk("invOrder", {evq[0], evq[1], evq[2]}, 9'o036);
    ev[11] = 1'b0;
    cyc(4);
    chk("invGone", invA, 0);
    clr();
  endtask

  task automatic t_predis;
    ev[8] = 1'b1;
    cyc(5);
    chk("cdLoad", cdSec inside {8'h02, 8'h03}, 1);
    chk("noRelEarly", led[0], 0);
    cyc(40);
    ev[8] = 1'b0;
    press(0);
    chk("relLatch", led[1:0], 2'b11);
    clr();
    chk("relClr", led, 0);
  endtask

  task automatic t_abort;
    ev[0] = 1'b1;
    ev[8] = 1'b1;
    cyc(4);
    ev[11] = 1'b1;
    cyc(60);
    chk("abortHold", {led[0], invA}, 0);
    ev[11] = 1'b0;
    cyc(40);
    press(0);
    chk("abortRest", led[0], 1);
    clr();
    ev[0] = 1'b1;
    ev[8] = 1'b1;
    ev[11] = 1'b1;
    cyc(8);
    ev[9] = 1'b1;
    cyc(5);
    chk("manOverride", cdSec <= 8'h01, 1);
    ev[10] = 1'b1;
    cyc(4);
    press(0);
    chk("manRelease", led[0], 1);
    clr();
  endtask

  task automatic t_verify;
    verifyEnCfg = 1'b1;
    ev[1] = 1'b1;
    cyc(6);
    chk("verOn", verZ, 1);
    chk("verQuiet", {led, snd, evq[0]}, 10'h002);
    cyc(40);
    chk("verAlarm", {verZ, zone[3]}, 2'b01);
    clr();
    verifyEnCfg = 1'b0;
  endtask

  task automatic t_supv;
    supvLatchCfg = 1'b1;
    ev[6] = 1'b1;
    cyc(4);
    watch(4);
    chk("supWarble", on > 0 && on < 16 && sn > 0 && sn < 16, 1);
    ev[6] = 1'b0;
    press(0);
    watch(4);
    chk("supLatch", on == 16 && sn == 0 && supI, 1);
    clr();
    supvLatchCfg = 1'b0;
    ev[7] = 1'b1;
    watch(4);
    chk("zoneDisSup", on > 0, 1);
    ev[7] = 1'b0;
    cyc(4);
    chk("supNoLatch", led[4], 0);
    clr();
  endtask

  task automatic t_view;
    ev[2] = 1'b1;
    cyc(4);
    ev[2] = 1'b0;
    chk("viewOn", view, 1);
    cyc(400);
    press(3);
    cyc(740);
    chk("viewHeld", view, 1);
    cyc(110);
    chk("viewBack", view, 0);
  endtask

  initial
  begin
    repeat (8) @(posedge sys_clk);
    #2 rst_b = 1'b1;
    cyc(2);
    chk("relayIdle", {relay, led, view}, 8'h80);
    t_trouble();
    t_alarm();
    t_inv_abort();
    t_predis();
    t_abort();
    t_verify();
    t_supv();
    t_view();
    close_out();
  end

  // Whole run needs about 1750 cycles
  initial
  begin
    #(25 * 6000);
    errors++;
    close_out();
  end
endmodule

// ---- spe_field_devices.sv ----
// Purpose: Field device and operator button model facing the event-state block
// Assumes: Bench sets request levels just after a clock edge
// Notes:   Reports arrive one edge late; a button request gives one pulse
`timescale 1ns/100ps
module spe_field_devices (
  // Clock
  input  wire logic        sys_clk,
  // Bench requests
  input  wire logic [11:0] evReq,
  input  wire logic [3:0]  btnReq,
  // Toward the panel
  output logic      [11:0] evOut,
  output logic      [3:0]  btnOut
);
  logic [3:0] btnPrev;

  initial
  begin
    evOut   = 12'h000;
    btnOut  = 4'h0;
    btnPrev = 4'h0;
  end

  // Held button still gives a single pulse, as a real key debounce would
  always @(posedge sys_clk)
  begin
    evOut   <= evReq;
    btnPrev <= btnReq;
    btnOut  <= btnReq & ~btnPrev;
  end
endmodule

// ---- spe_pkg.sv ----
// Purpose: Shared constants and types for the suppression panel event-state block
// Assumes: 40 MHz sys_clk
// Notes:   Priority index 0 is the most urgent indicator
package spe_pkg;

  localparam int CLK_HZ        = 40_000_000;
  localparam int FLASH_HALF_MS = 500;
  localparam int HALF_CYC      = CLK_HZ / 1000 * FLASH_HALF_MS;
  localparam int DISP_TIMEOUT_S = 100;
  localparam int VERIFY_S_DEF  = 60;

  localparam int CD_W   = 8;
  localparam int DISP_W = 7;
  localparam int VER_W  = 8;

  // Indicator indices, most urgent first
  localparam int NST      = 6;
  localparam int IX_REL   = 0;
  localparam int IX_PRED  = 1;
  localparam int IX_ABORT = 2;
  localparam int IX_ALM   = 3;
  localparam int IX_SUPV  = 4;
  localparam int IX_TRB   = 5;

  // Event log codes; lower code is reported first
  localparam int NEV          = 8;
  localparam int EV_INV_ABORT = 0;
  localparam int EV_ALARM     = 1;
  localparam int EV_VERIFY    = 2;
  localparam int EV_TROUBLE   = 3;
  localparam int EV_SUPV      = 4;
  localparam int EV_PREDIS    = 5;
  localparam int EV_ABORT     = 6;
  localparam int EV_RELEASE   = 7;

  localparam logic RELAY_RST = 1'b1;

  typedef logic [CD_W-1:0] spe_sec_t;
  typedef enum logic [1:0] {PD_IDLE, PD_COUNT, PD_ABORT, PD_RELEASE} spe_pd_e;
  typedef enum logic {VER_IDLE, VER_RUN} spe_ver_e;

endpackage
